// File: core/ceod_decoder.sv
// Instruction decoder for the crypto extension, one registered stage.
// Assumes fetch delivers a word with a same-clock valid strobe.
`include "ceod_consts.svh"
`default_nettype none

// Overview of operation
// - Codes reserved for future use raise a reserved-instruction exception.
// - Field-class codes are decoded further through a secondary field.
// - Codes for a higher instruction-set level raise reserved-instruction.
// - Empty partner codes: reserved, or unusable if coprocessor disallowed.
// - Optional debug encodings: reserved if absent, exact code if present.
// - Extension codes raise reserved-instruction when extension is absent.
// - Opcode 000000 is register group, 011100 the second group.
// - Register functions 000010 and 000110 are shift field classes.
// - Functions 010010, 010011, 011001 need secondary decode.
// - Pages support true read-only, write-only, execute-only protection.
// - Memory management supports 2K and 1K virtual pages.
// - Context register is a flexible variant for faster lookups.
// - Page protection and flexible context are always present.
// - Immediate shift class: bit 21 picks logical or rotate.
// - Variable shift class: bit 6 picks logical or rotate.
// - Move-from-low class: 00000 plain, 00001 extended accumulator.
// - Unsigned multiply class: 00000 plain, 10001 polynomial.
module ceod_decoder #(
  parameter bit EXT_PRESENT = 1'b1  // Extension built in
) (
  input  wire logic        i_clk_sys,      // Core clock, 100 MHz
  input  wire logic        i_rst_n,        // Async reset, active low
  input  wire logic        i_insn_valid,   // Fetch word valid
  input  wire logic [31:0] i_insn,         // Fetch instruction word
  input  wire logic        i_cop2_usable,  // Partner coprocessor allowed
  input  wire logic        i_base_rsvd,    // Base decoder says reserved
  output logic             o_valid,        // Decode result valid
  output ceod_pkg::ceod_op_t o_op,         // Decoded operation
  output logic             o_exc_rsvd,     // Reserved-instruction exc
  output logic             o_exc_cpu,      // Coprocessor-unusable exc
  output logic             o_to_mul,       // Route to multiply unit
  output logic             o_pg_read_inh,  // Read-inhibit supported
  output logic             o_pg_exec_inh,  // Execute-inhibit supported
  output logic             o_ctx_flex,     // Flexible context present
  output logic             o_small_pages   // 1K/2K pages supported
);

  // ************************************************************
  // Field extraction
  // ************************************************************
  logic [5:0] opcode;
  logic [5:0] funct;
  logic [4:0] sa_field;
  assign opcode   = i_insn[31:26];
  assign funct    = i_insn[5:0];
  assign sa_field = i_insn[10:6];

  // Multiply-unit destinations share one test
  function automatic logic is_mul_op(input ceod_pkg::ceod_op_t op);
    is_mul_op = (op inside {ceod_pkg::CEOD_OP_MF_LO,
                            ceod_pkg::CEOD_OP_MF_XACC,
                            ceod_pkg::CEOD_OP_MT_LO,
                            ceod_pkg::CEOD_OP_MT_XACC,
                            ceod_pkg::CEOD_OP_MUL_U,
                            ceod_pkg::CEOD_OP_MUL_POLY,
                            ceod_pkg::CEOD_OP_MADD_U,
                            ceod_pkg::CEOD_OP_MADD_P});
  endfunction

  // ************************************************************
  // Field-class sub-decodes
  // ************************************************************
  // Every sub-decode below except the two shift decodes hands back CEOD_OP_NONE
  // for a secondary value that names no instruction. NONE is never a legal
  // decode, so the caller turns it straight into a reserved-instruction
  // exception and no unassigned code of those classes reaches an execution unit.

  // Immediate shift class. Bit 21 turns the logical shift into a rotate;
  // the base set keeps that bit zero, so older code keeps its meaning.
  function automatic ceod_pkg::ceod_op_t dec_shift_imm(
    input logic [31:0] w  // Whole instruction word
  );
    if (w[`CEOD_ROT_IMM_BIT]) begin
      dec_shift_imm = ceod_pkg::CEOD_OP_ROT_IMM;
    end else begin
      dec_shift_imm = ceod_pkg::CEOD_OP_SRL_IMM;
    end
  endfunction

  // Variable shift class. Bit 6 picks the rotate. Only that bit is
  // looked at; the other sub-field bits are left to the execute stage.
  function automatic ceod_pkg::ceod_op_t dec_shift_var(
    input logic [31:0] w  // Whole instruction word
  );
    if (w[`CEOD_ROT_VAR_BIT]) begin
      dec_shift_var = ceod_pkg::CEOD_OP_ROT_VAR;
    end else begin
      dec_shift_var = ceod_pkg::CEOD_OP_SRL_VAR;
    end
  endfunction

  // Accumulator move classes. Move-from and move-to share one layout:
  // the plain code reaches the low accumulator and the next code reaches
  // the extended accumulator. One function serves both directions.
  function automatic ceod_pkg::ceod_op_t dec_acc_move(
    input logic [4:0]         sa,        // Secondary field, bits 10:6
    input ceod_pkg::ceod_op_t plain_op,  // Result for the plain code
    input ceod_pkg::ceod_op_t xacc_op    // Result for the extended code
  );
    if (sa == `CEOD_SA_PLAIN) begin
      dec_acc_move = plain_op;
    end else if (sa == `CEOD_SA_EXT) begin
      dec_acc_move = xacc_op;
    end else begin
      dec_acc_move = ceod_pkg::CEOD_OP_NONE;
    end
  endfunction

  // Unsigned multiply class: plain integer product, or the carry-less
  // polynomial product used by public-key code.
  function automatic ceod_pkg::ceod_op_t dec_mul_u(
    input logic [4:0] sa  // Secondary field, bits 10:6
  );
    if (sa == `CEOD_SA_PLAIN) begin
      dec_mul_u = ceod_pkg::CEOD_OP_MUL_U;
    end else if (sa == `CEOD_SA_POLY) begin
      dec_mul_u = ceod_pkg::CEOD_OP_MUL_POLY;
    end else begin
      dec_mul_u = ceod_pkg::CEOD_OP_NONE;
    end
  endfunction

  // Multiply-add class of the second group: plain, polynomial, or the
  // partial bit permutation that shares the same function code.
  function automatic ceod_pkg::ceod_op_t dec_madd(
    input logic [4:0] sa  // Secondary field, bits 10:6
  );
    if (sa == `CEOD_SA_PLAIN) begin
      dec_madd = ceod_pkg::CEOD_OP_MADD_U;
    end else if (sa == `CEOD_SA_POLY) begin
      dec_madd = ceod_pkg::CEOD_OP_MADD_P;
    end else if (sa == `CEOD_SA_PERM) begin
      dec_madd = ceod_pkg::CEOD_OP_PERM;
    end else begin
      dec_madd = ceod_pkg::CEOD_OP_NONE;
    end
  endfunction

  // Indexed load class: one assigned code, the scaled word load.
  function automatic ceod_pkg::ceod_op_t dec_load_x(
    input logic [4:0] sa  // Secondary field, bits 10:6
  );
    if (sa == `CEOD_SA_EXT) begin
      dec_load_x = ceod_pkg::CEOD_OP_LOAD_X;
    end else begin
      dec_load_x = ceod_pkg::CEOD_OP_NONE;
    end
  endfunction

  // ************************************************************
  // Group decodes
  // ************************************************************
  // Register-format group. The listed function codes are field classes,
  // so the decision waits for the secondary field; any other function
  // code is left untouched for the base decoder.
  function automatic ceod_pkg::ceod_op_t dec_reg_group(
    input logic [5:0]  fn,  // Function field, bits 5:0
    input logic [31:0] w    // Whole instruction word
  );
    logic [4:0] sa;
    sa = w[10:6];
    if (fn == `CEOD_FN_SRL_IMM) begin
      dec_reg_group = dec_shift_imm(w);
    end else if (fn == `CEOD_FN_SRL_VAR) begin
      dec_reg_group = dec_shift_var(w);
    end else if (fn == `CEOD_FN_MF_LO) begin
      dec_reg_group = dec_acc_move(sa, ceod_pkg::CEOD_OP_MF_LO,
                                   ceod_pkg::CEOD_OP_MF_XACC);
    end else if (fn == `CEOD_FN_MT_LO) begin
      dec_reg_group = dec_acc_move(sa, ceod_pkg::CEOD_OP_MT_LO,
                                   ceod_pkg::CEOD_OP_MT_XACC);
    end else if (fn == `CEOD_FN_MUL_U) begin
      dec_reg_group = dec_mul_u(sa);
    end else begin
      dec_reg_group = ceod_pkg::CEOD_OP_BASE;
    end
  endfunction

  // Second opcode group. Only the two extension classes are decoded
  // here; the group's other function codes belong to the base set.
  function automatic ceod_pkg::ceod_op_t dec_second_group(
    input logic [5:0] fn,  // Function field, bits 5:0
    input logic [4:0] sa   // Secondary field, bits 10:6
  );
    if (fn == `CEOD_FN2_MADD_U) begin
      dec_second_group = dec_madd(sa);
    end else if (fn == `CEOD_FN2_LOAD_X) begin
      dec_second_group = dec_load_x(sa);
    end else begin
      dec_second_group = ceod_pkg::CEOD_OP_BASE;
    end
  endfunction

  // Operations that exist only with the extension. The plain shifts,
  // moves and multiplies keep working in a build without it, since they
  // are ordinary base instructions that merely share a field class.
  function automatic logic is_ext_only(input ceod_pkg::ceod_op_t op);
    is_ext_only = (op inside {ceod_pkg::CEOD_OP_ROT_IMM,
                              ceod_pkg::CEOD_OP_ROT_VAR,
                              ceod_pkg::CEOD_OP_MF_XACC,
                              ceod_pkg::CEOD_OP_MT_XACC,
                              ceod_pkg::CEOD_OP_MUL_POLY,
                              ceod_pkg::CEOD_OP_MADD_P,
                              ceod_pkg::CEOD_OP_PERM,
                              ceod_pkg::CEOD_OP_LOAD_X});
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  ceod_pkg::ceod_state_t st;
  ceod_pkg::ceod_state_t next_st;

  // Classify the word; unlisted codes fall to the base decoder
  always_comb begin
    ceod_pkg::ceod_op_t op;
    logic               rsvd;
    logic               cpu;
    op   = ceod_pkg::CEOD_OP_BASE;
    rsvd = 1'b0;
    cpu  = 1'b0;
    // Primary opcode picks the group; both groups are field classes
    if (opcode == `CEOD_OP_REG_GROUP) begin
      op = dec_reg_group(funct, i_insn);
    end else if (opcode == `CEOD_OP_SECOND_GRP) begin
      op = dec_second_group(funct, sa_field);
    end
    // A sub-decode that found no instruction answers NONE
    if (op == ceod_pkg::CEOD_OP_NONE) begin
      rsvd = 1'b1;
    end
    // Extension absent: its codes become reserved
    if (!EXT_PRESENT && is_ext_only(op)) begin
      rsvd = 1'b1;
    end
    // Base decoder flags future, higher-level, debug codes
    if (op == ceod_pkg::CEOD_OP_BASE && i_base_rsvd) begin
      // Empty partner coprocessor slot: unusable if blocked
      if (opcode == `CEOD_OP_COP2 && !i_cop2_usable) begin
        cpu = 1'b1;
      end else begin
        rsvd = 1'b1;
      end
    end
    if (rsvd || cpu) begin
      op = ceod_pkg::CEOD_OP_NONE;
    end
    next_st.valid    = i_insn_valid;
    next_st.op       = i_insn_valid ? op : ceod_pkg::CEOD_OP_NONE;
    next_st.exc_rsvd = i_insn_valid & rsvd;
    next_st.exc_cpu  = i_insn_valid & cpu;
    next_st.to_mul   = i_insn_valid & is_mul_op(op);
  end

  // Single pipeline register; cleared to an idle slot
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{1'b0, ceod_pkg::CEOD_OP_NONE, 1'b0, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_valid       = st.valid;
  assign o_op          = st.op;
  assign o_exc_rsvd    = st.exc_rsvd;
  assign o_exc_cpu     = st.exc_cpu;
  assign o_to_mul      = st.to_mul;
  // Capability straps to the memory unit; always on here, not optional
  assign o_pg_read_inh = 1'b1;
  assign o_pg_exec_inh = 1'b1;
  assign o_ctx_flex    = 1'b1;
  assign o_small_pages = 1'b1;

endmodule
`default_nettype wire

// File: core/ceod_consts.svh
// Opcode, function and sub-field codes for the extension decoder.
// Assumes 32-bit instruction words with the usual field layout.
`ifndef CEOD_CONSTS_SVH
`define CEOD_CONSTS_SVH
// ************************************************************
// Field codes
// ************************************************************
`define CEOD_OP_REG_GROUP   6'h00
`define CEOD_OP_SECOND_GRP  6'h1c
`define CEOD_OP_COP2        6'h12
`define CEOD_FN_SRL_IMM     6'h02
`define CEOD_FN_SRL_VAR     6'h06
`define CEOD_FN_MF_LO       6'h12
`define CEOD_FN_MT_LO       6'h13
`define CEOD_FN_MUL_U       6'h19
`define CEOD_FN2_MADD_U     6'h01
`define CEOD_FN2_LOAD_X     6'h08
`define CEOD_SA_PLAIN       5'h00
`define CEOD_SA_EXT         5'h01
`define CEOD_SA_POLY        5'h11
`define CEOD_SA_PERM        5'h12
`define CEOD_ROT_IMM_BIT    21
`define CEOD_ROT_VAR_BIT    6
`define CEOD_RESET_INSN     32'h0000_0000
`endif

// File: core/ceod_pkg.sv
// Types shared by the extension decoder and its users.
// Assumes ceod_consts.svh supplies the numeric codes.
`default_nettype none
package ceod_pkg;
  // Decoded operation classes
  typedef enum logic [3:0] {
    CEOD_OP_NONE     = 4'b0000,
    CEOD_OP_BASE     = 4'b0001,
    CEOD_OP_SRL_IMM  = 4'b0010,
    CEOD_OP_ROT_IMM  = 4'b0011,
    CEOD_OP_SRL_VAR  = 4'b0100,
    CEOD_OP_ROT_VAR  = 4'b0101,
    CEOD_OP_MF_LO    = 4'b0110,
    CEOD_OP_MF_XACC  = 4'b0111,
    CEOD_OP_MT_LO    = 4'b1000,
    CEOD_OP_MT_XACC  = 4'b1001,
    CEOD_OP_MUL_U    = 4'b1010,
    CEOD_OP_MUL_POLY = 4'b1011,
    CEOD_OP_MADD_U   = 4'b1100,
    CEOD_OP_MADD_P   = 4'b1101,
    CEOD_OP_PERM     = 4'b1110,
    CEOD_OP_LOAD_X   = 4'b1111
  } ceod_op_t;

  // Registered decoder state
  typedef struct packed {
    logic     valid;
    ceod_op_t op;
    logic     exc_rsvd;
    logic     exc_cpu;
    logic     to_mul;
  } ceod_state_t;
endpackage
`default_nettype wire

// File: verification/ceod_decoder_sva.sv
// Checker for the extension decoder, watching its ports only.
// Assumes the extension is built in (default parameter).
`default_nettype none
module ceod_decoder_sva (
  input wire logic               i_clk_sys,     // Core clock
  input wire logic               i_rst_n,       // Async reset
  input wire logic               i_insn_valid,  // Word valid
  input wire logic [31:0]        i_insn,        // Word
  input wire logic               i_cop2_usable, // Partner allowed
  input wire logic               i_base_rsvd,   // Base verdict
  input wire logic               o_valid,       // Result valid
  input wire ceod_pkg::ceod_op_t o_op,          // Operation
  input wire logic               o_exc_rsvd,    // Reserved exc
  input wire logic               o_exc_cpu,     // Unusable exc
  input wire logic               o_pg_read_inh, // Capability
  input wire logic               o_pg_exec_inh, // Capability
  input wire logic               o_ctx_flex,    // Capability
  input wire logic               o_small_pages  // Capability
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Base verdict low, so only extension decode is judged
  wire reg_grp = i_insn_valid && i_insn[31:26] == 6'h00 && !i_base_rsvd;
  AST_VALID: assert property ($past(i_rst_n) |-> o_valid == $past(i_insn_valid))
    else $error("valid not one cycle after fetch");
  AST_IDLE: assert property (!o_valid |-> o_op == 4'h0 && !o_exc_rsvd && !o_exc_cpu)
    else $error("idle cycle shows a result");
  AST_EXC: assert property (o_exc_rsvd || o_exc_cpu |-> o_op == 4'h0 && !(o_exc_rsvd && o_exc_cpu))
    else $error("exception with an operation");
  AST_ROT_IMM: assert property ($past(i_rst_n && reg_grp && i_insn[5:0] == 6'h02) |-> o_op == ($past(i_insn[21]) ? 4'h3 : 4'h2))
    else $error("bit 21 shift select wrong");
  AST_ROT_VAR: assert property ($past(i_rst_n && reg_grp && i_insn[5:0] == 6'h06) |-> o_op == ($past(i_insn[6]) ? 4'h5 : 4'h4))
    else $error("bit 6 shift select wrong");
  AST_MF_RSVD: assert property ($past(i_rst_n && reg_grp && i_insn[5:0] == 6'h12 && i_insn[10:6] > 5'h01) |-> o_exc_rsvd)
    else $error("unassigned sub-code accepted");
  AST_CPU: assert property ($past(i_rst_n && i_insn_valid && i_insn[31:26] == 6'h12 && i_base_rsvd) |-> o_exc_cpu == $past(!i_cop2_usable) && o_exc_rsvd == $past(i_cop2_usable))
    else $error("partner code exception wrong");
  AST_CAPS: assert property (o_pg_read_inh && o_pg_exec_inh && o_ctx_flex && o_small_pages)
    else $error("memory capability missing");
endmodule
bind ceod_decoder ceod_decoder_sva i_ceod_decoder_sva (.*);
`default_nettype wire

// File: verification/ceod_fetch_model.sv
// Fetch-stage model presenting one word at a time to the decoder.
// Assumes the bench calls send and samples the results itself.
`default_nettype none
module ceod_fetch_model (
  input  wire logic        i_clk_sys,    // Core clock
  output logic             o_insn_valid, // Word valid
  output logic [31:0]      o_insn,       // Instruction word
  output logic             o_base_rsvd,  // Base decoder verdict
  output logic             o_cop2_usable // Partner access allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_insn_valid, o_insn, o_base_rsvd, o_cop2_usable} = '0;
  // One word for one cycle; no obsolete codes are ever sent
  task automatic send(input logic [31:0] w, input logic r, c);
    @(posedge i_clk_sys);
    o_insn_valid <= 1'b1;
    o_insn <= w;
    o_base_rsvd <= r;
    o_cop2_usable <= c;
    @(posedge i_clk_sys);
    o_insn_valid <= 1'b0;
    o_insn <= ~w; // Word is not held once taken
  endtask
endmodule
`default_nettype wire

// File: verification/test_ceod_decoder.sv
// Self-checking bench for the extension decoder.
// Assumes the package, decoder, model and checker compile first.
`default_nettype none
module test_ceod_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               valid, rsvd, cop, o_valid, er, ec, mul;
  logic               rd, ex, cx, sp;
  logic [31:0]        insn;
  ceod_pkg::ceod_op_t op;
  int                 miscompares = 0;
  int                 n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  ceod_fetch_model i_ceod_fetch_model (.i_clk_sys(clk_sys),
    .o_insn_valid(valid), .o_insn(insn), .o_base_rsvd(rsvd),
    .o_cop2_usable(cop));
  ceod_decoder i_ceod_decoder (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_insn_valid(valid), .i_insn(insn), .i_cop2_usable(cop),
    .i_base_rsvd(rsvd), .o_valid(o_valid), .o_op(op), .o_exc_rsvd(er),
    .o_exc_cpu(ec), .o_to_mul(mul), .o_pg_read_inh(rd),
    .o_pg_exec_inh(ex), .o_ctx_flex(cx), .o_small_pages(sp));
  // Compare and report; an unknown bit matches only an unknown bit
  task automatic cmp(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Send one word; an x in m means multiply routing is not judged
  task automatic dec(input logic [31:0] w, input logic r, c,
                     input logic [3:0] o, input logic e, u, m);
    i_ceod_fetch_model.send(w, r, c);
    #1;
    cmp({o_valid, op, er, ec, (m === 1'bx) ? 1'bx : mul},
        {1'b1, o, e, u, m});
  endtask
  task automatic t_shift;
    dec(32'h0000_0002, 0, 0, 4'h2, 0, 0, 0);
    dec(32'h0020_0002, 0, 0, 4'h3, 0, 0, 0);
    dec(32'h0000_0006, 0, 0, 4'h4, 0, 0, 0);
    dec(32'h0000_0046, 0, 0, 4'h5, 0, 0, 0);
  endtask
  task automatic t_acc;
    dec(32'h0000_0012, 0, 0, 4'h6, 0, 0, 1);
    dec(32'h0000_0052, 0, 0, 4'h7, 0, 0, 1);
    dec(32'h0000_0092, 0, 0, 4'h0, 1, 0, 1'bx);
    dec(32'h0000_0013, 0, 0, 4'h8, 0, 0, 1);
    dec(32'h0000_0053, 0, 0, 4'h9, 0, 0, 1);
    dec(32'h0000_0019, 0, 0, 4'ha, 0, 0, 1);
    dec(32'h0000_0459, 0, 0, 4'hb, 0, 0, 1);
    dec(32'h0000_0059, 0, 0, 4'h0, 1, 0, 1'bx);
  endtask
  task automatic t_second;
    dec(32'h7000_0001, 0, 0, 4'hc, 0, 0, 1);
    dec(32'h7000_0441, 0, 0, 4'hd, 0, 0, 1);
    dec(32'h7000_0481, 0, 0, 4'he, 0, 0, 1'bx);
    dec(32'h7000_0048, 0, 0, 4'hf, 0, 0, 0);
    dec(32'h7000_0081, 0, 0, 4'h0, 1, 0, 1'bx);
  endtask
  task automatic t_base;
    dec(32'h0000_0021, 0, 0, 4'h1, 0, 0, 0);
    dec(32'h0000_0021, 1, 0, 4'h0, 1, 0, 1'bx);
    dec(32'h4800_0000, 1, 0, 4'h0, 0, 1, 1'bx);
    dec(32'h4800_0000, 1, 1, 4'h0, 1, 0, 1'bx);
    @(posedge clk_sys);
    #1;
    cmp({o_valid, op, er, ec, 1'b0}, 8'h00);
    cmp({4'h0, rd, ex, cx, sp}, 8'h0f);
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Whole run is near 46 cycles; a twentyfold margin catches hangs
  initial begin
    #10000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_shift;
    t_acc;
    t_second;
    t_base;
    finish_test;
  end
endmodule
`default_nettype wire
